// *** hw/lcd_display_ram.sv ***
// Display pattern memory: byte port for software, whole-row port for refresh
`timescale 1ns/1ps
module lcd_display_ram #(
    parameter int ROWS = 8,
    parameter int GROUPS = 5
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [5:0] raddr,
    output logic [7:0] rdata_q,
    input wire logic [2:0] row_sel,
    output logic [GROUPS*8-1:0] row_bits_q
);
    // Byte at group*ROWS + row; no reset, software must load the pattern
    logic [7:0] mem [ROWS*GROUPS];

    // ----------------------------------------
    // Software port
    // ----------------------------------------
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end

    // ----------------------------------------
    // Refresh port: one byte per segment group for the selected row
    // ----------------------------------------
    for (genvar g = 0; g < GROUPS; g++) begin : g_group
        always_ff @(posedge pclk) begin
            row_bits_q[g*8 +: 8] <= mem[g*ROWS + int'(row_sel)]; // RULE12
        end
        // Case equality, since bytes that software has not loaded yet stay unknown
        a_row_byte_map: assert property (@(posedge pclk) // RULE12
            row_bits_q[g*8 +: 8] === $past(mem[g*ROWS + int'(row_sel)]))
            else $error("row byte does not follow group and row");
    end

endmodule : lcd_display_ram

// *** hw/lcd_pkg.sv ***
// Shared constants and types for the segment LCD driver control block
package lcd_pkg;

    // ----------------------------------------
    // Panel geometry
    // ----------------------------------------
    localparam int ROWS = 8;
    localparam int GROUPS = 5;
    localparam int SEGS = 40;
    localparam int SHARED_PADS = 32;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [9:0] IDX_CONTROL = 10'h000;
    localparam logic [9:0] IDX_STATUS = 10'h001;
    localparam logic [9:0] IDX_RAM_FIRST = 10'h0D8;
    localparam logic [9:0] IDX_RAM_LAST = 10'h0FF;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int BIT_DRIVER_ON = 0;
    localparam int BIT_BLANK = 1;
    localparam int BIT_TYPE = 2;
    localparam logic [2:0] CONTROL_RESET = 3'h0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic type_b;
        logic blank;
        logic driver_on;
    } lcd_ctrl_s;

    typedef enum logic {APB_IDLE, APB_ACK} apb_state_e;

endpackage : lcd_pkg

// *** hw/segment_lcd_driver_control.sv ***
// APB register file, display memory map and refresh for a multiplexed segment LCD
// Operation
// (RULE1) Control bit 2 selects the type A waveform at 0 and the type B waveform at 1.
// (RULE2) Control bit 1 at 1 blanks the panel by changing only the row outputs, columns untouched.
// (RULE3) Control bit 0 at 0 disables the driver so no row or column output is driven.
// (RULE4) Software clears the driver-on bit before it puts the chip to sleep.
// (RULE5) Refresh timing comes from the slow clock, not the fast system clock.
// (RULE6) Software cannot expect a proper picture while only the fast clock runs.
// (RULE7) In dual-clock operation the driver is paced by the slow clock.
// (RULE8) For row 0 the segment group bytes sit at D8H, E0H, E8H, F0H and F8H.
// (RULE9) Each group's byte address rises by one per row, ending at DFH, E7H, EFH, F7H and FFH.
// (RULE10) The LCD regulator runs only when its mask option is 1.
// (RULE11) A shared pad drives a segment when its select option is 1 and is port I/O when 0.
// (RULE12) Bit n of a display byte controls segment (group base + n) on that byte's row.
// (RULE13) Control bits 7 to 3 read as zero and ignore writes.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module segment_lcd_driver_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_clk,
    input wire logic regulator_option,
    input wire logic [31:0] shared_pad_lcd_select,
    output logic [7:0] row_drive,
    output logic [39:0] column_drive,
    output logic [39:0] column_active,
    output logic drive_enable,
    output logic regulator_enable
);
    localparam int SEGS = lcd_pkg::SEGS;
    localparam int ROWS = lcd_pkg::ROWS;

    lcd_pkg::lcd_ctrl_s ctrl_q;
    lcd_pkg::apb_state_e apb_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic slow_q, pol_q, strap_taken_q, regulator_opt_q, regulator_enable_q;
    logic [31:0] pad_select_q;
    logic [2:0] row_q, row_dly_q;
    logic [7:0] row_drive_q;
    logic [SEGS-1:0] column_drive_q, column_active_q, row_bits_q;
    logic drive_enable_q;
    logic [7:0] ram_rdata_q;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire [9:0] idx = paddr[11:2];
    wire hit_control = (idx == lcd_pkg::IDX_CONTROL);
    wire hit_status = (idx == lcd_pkg::IDX_STATUS);
    wire hit_ram = (idx >= lcd_pkg::IDX_RAM_FIRST) && (idx <= lcd_pkg::IDX_RAM_LAST); // RULE8 RULE9
    wire [9:0] ram_off = idx - lcd_pkg::IDX_RAM_FIRST;
    wire [5:0] ram_addr = ram_off[5:0]; // Offset = group*8 + row, RULE9
    wire mapped = hit_control || hit_status || hit_ram;
    wire access = psel && penable;
    wire commit = access && (apb_q == lcd_pkg::APB_ACK);
    wire ram_we = commit && pwrite && hit_ram;
    wire ctrl_we = commit && pwrite && hit_control;

    // Read mux; unused control bits read zero
    wire [31:0] ctrl_word = {29'h0000_0000, ctrl_q}; // RULE13
    wire [31:0] status_word = {28'h000_0000, row_q, pol_q};
    wire [31:0] read_word = hit_control ? ctrl_word :
                            hit_status ? status_word :
                            hit_ram ? {24'h00_0000, ram_rdata_q} : 32'h0000_0000;

    // ----------------------------------------
    // APB slave: one wait state, so the memory read settles before data is returned
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_q <= lcd_pkg::APB_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            case (apb_q)
                lcd_pkg::APB_IDLE: begin
                    if (access) begin
                        apb_q <= lcd_pkg::APB_ACK;
                        pready_q <= 1'b1;
                        pslverr_q <= !mapped;
                        prdata_q <= pwrite ? 32'h0000_0000 : read_word;
                    end
                end
                lcd_pkg::APB_ACK: begin
                    apb_q <= lcd_pkg::APB_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
                default: apb_q <= lcd_pkg::APB_IDLE;
            endcase
        end
    end

    // Control register; only the three defined bits are stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= lcd_pkg::CONTROL_RESET;
        end else if (ctrl_we) begin
            ctrl_q <= pwdata[lcd_pkg::BIT_TYPE:lcd_pkg::BIT_DRIVER_ON]; // RULE13
        end
    end

    // ----------------------------------------
    // Mask options: caught once at the first edge after reset release
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_taken_q <= 1'b0;
            regulator_opt_q <= 1'b0;
            pad_select_q <= 32'h0000_0000;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            regulator_opt_q <= regulator_option;
            pad_select_q <= shared_pad_lcd_select;
        end
    end

    // ----------------------------------------
    // Refresh sequencer paced by slow clock edges
    // ----------------------------------------
    // Fast-clock-only systems would tie slow_clk to a fast source and scan too quickly
    wire slow_tick = slow_clk && !slow_q; // RULE5 RULE7
    wire frame_wrap = (row_q == 3'(ROWS - 1));
    wire pol_flip = ctrl_q.type_b ? frame_wrap : 1'b1; // RULE1

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_q <= 1'b0;
            row_q <= 3'h0;
            pol_q <= 1'b0;
        end else begin
            slow_q <= slow_clk;
            if (slow_tick) begin
                row_q <= row_q + 3'h1; // RULE5
                pol_q <= pol_q ^ pol_flip; // RULE1
            end
        end
    end

    // Row data from memory arrives one cycle after row_q; delay the row to match
    wire [7:0] row_select = 8'h01 << row_dly_q;
    wire [39:0] pad_lcd = {pad_select_q, 8'hFF}; // RULE11

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_dly_q <= 3'h0;
            row_drive_q <= 8'h00;
            column_drive_q <= 40'h00_0000_0000;
            column_active_q <= 40'h00_0000_0000;
            drive_enable_q <= 1'b0;
            regulator_enable_q <= 1'b0;
        end else begin
            row_dly_q <= row_q;
            regulator_enable_q <= regulator_opt_q && strap_taken_q; // RULE10
            drive_enable_q <= ctrl_q.driver_on; // RULE3
            if (!ctrl_q.driver_on) begin
                row_drive_q <= 8'h00; // RULE3
                column_drive_q <= 40'h00_0000_0000;
                column_active_q <= 40'h00_0000_0000;
            end else begin
                row_drive_q <= ctrl_q.blank ? {8{pol_q}} : (row_select ^ {8{pol_q}}); // RULE2
                column_drive_q <= (row_bits_q ^ {SEGS{pol_q}}) & pad_lcd; // RULE11 RULE12
                column_active_q <= pad_lcd; // RULE11
            end
        end
    end

    lcd_display_ram #(
        .ROWS(lcd_pkg::ROWS),
        .GROUPS(lcd_pkg::GROUPS)
    ) u_ram (
        .pclk(pclk),
        .we(ram_we),
        .waddr(ram_addr),
        .wdata(pwdata[7:0]),
        .raddr(ram_addr),
        .rdata_q(ram_rdata_q),
        .row_sel(row_q),
        .row_bits_q(row_bits_q)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign row_drive = row_drive_q;
    assign column_drive = column_drive_q;
    assign column_active = column_active_q;
    assign drive_enable = drive_enable_q;
    assign regulator_enable = regulator_enable_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // The release edge still runs the reset branch, so polarity checks wait for the first live edge
    a_type_a_flip: assert property (@(posedge pclk) disable iff (!presetn || !strap_taken_q) // RULE1
        slow_tick && !ctrl_q.type_b |=> pol_q != $past(pol_q))
        else $error("type A polarity did not flip per row");
    a_type_b_hold: assert property (@(posedge pclk) disable iff (!presetn || !strap_taken_q) // RULE1
        slow_tick && ctrl_q.type_b && !frame_wrap |=> pol_q == $past(pol_q))
        else $error("type B polarity flipped inside a frame");
    a_blank_rows: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        ctrl_q.driver_on && ctrl_q.blank |=> row_drive_q == {8{$past(pol_q)}})
        else $error("blank did not hold rows unselected");
    a_blank_columns: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        ctrl_q.driver_on && ctrl_q.blank |=> column_drive_q[7:0] == ($past(row_bits_q[7:0]) ^ {8{$past(pol_q)}}))
        else $error("blank changed column data");
    a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        !ctrl_q.driver_on |=> !drive_enable_q && row_drive_q == 8'h00 && column_active_q == 40'h00_0000_0000)
        else $error("disabled driver still drives");
    a_slow_pace: assert property (@(posedge pclk) disable iff (!presetn) // RULE5 RULE7
        row_q != $past(row_q) |-> $past(slow_tick))
        else $error("row advanced without a slow clock edge");
    a_ram_window: assert property (@(posedge pclk) disable iff (!presetn) // RULE8 RULE9
        ram_we |-> idx >= 10'h0D8 && idx <= 10'h0FF && ram_addr == idx[5:0] - 6'h18)
        else $error("display write outside its window");
    a_regulator_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        regulator_enable_q |-> $past(regulator_opt_q))
        else $error("regulator on without its option");
    a_pad_select: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        (column_active_q[39:8] & ~pad_select_q) == 32'h0000_0000)
        else $error("port pad driven as a segment");
    a_ctrl_reserved: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        commit && !pwrite && hit_control |-> prdata_q[31:3] == 29'h0000_0000)
        else $error("reserved control bits not zero");
    a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_q |=> pready_q)
        else $error("access phase not answered in one cycle");

endmodule : segment_lcd_driver_control

// *** verif/lcd_glass_model.sv ***
// Glass panel model: finds the selected row and the lit pixels
`timescale 1ns/1ps
module lcd_glass_model (
    input wire logic [7:0] row_drive,
    input wire logic [39:0] column_drive,
    input wire logic [39:0] column_active,
    input wire logic drive_enable,
    output logic [2:0] sel_row,
    output logic sel_valid,
    output logic polarity,
    output logic [39:0] pixels
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // One row must stand apart, else sel_valid stays low (blank or off); pixels are not gated by it
    always_comb begin
        int ones;
        ones = $countones(row_drive);
        polarity = (ones == 7);
        sel_valid = drive_enable && (ones == 1 || ones == 7);
        sel_row = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (row_drive[i] != polarity) begin
                sel_row = 3'(i);
            end
        end
        pixels = (column_drive ^ {40{polarity}}) & column_active;
    end
endmodule : lcd_glass_model

// *** verif/segment_lcd_driver_control_tb.sv ***
// Testbench for the segment LCD driver control block
`timescale 1ns/1ps
module segment_lcd_driver_control_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic slow_clk = 1'b0;
    logic slow_run = 1'b1;
    logic [3:0] slow_cnt = 4'h0;
    logic regulator_option = 1'b1;
    logic [31:0] shared_pad_lcd_select = 32'hFFFF_FFFF;
    logic [31:0] prdata;
    logic pready, pslverr, drive_enable, regulator_enable, sel_valid, polarity;
    logic [7:0] row_drive;
    logic [39:0] column_drive, column_active, pixels;
    logic [2:0] sel_row;
    logic [7:0] pol;
    int n_errors = 0;
    int comparisons = 0;

    always #5 pclk = ~pclk;

    // Slow clock of 20 fast cycles; stoppable to show refresh freezes
    always @(posedge pclk) begin
        if (slow_run) begin
            slow_cnt <= (slow_cnt == 4'h9) ? 4'h0 : slow_cnt + 4'h1;
            if (slow_cnt == 4'h9) begin
                slow_clk <= ~slow_clk;
            end
        end
    end

    segment_lcd_driver_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_clk(slow_clk), .regulator_option(regulator_option),
        .shared_pad_lcd_select(shared_pad_lcd_select), .row_drive(row_drive),
        .column_drive(column_drive), .column_active(column_active), .drive_enable(drive_enable),
        .regulator_enable(regulator_enable));
    lcd_glass_model panel_u (.row_drive(row_drive), .column_drive(column_drive),
        .column_active(column_active), .drive_enable(drive_enable), .sel_row(sel_row),
        .sel_valid(sel_valid), .polarity(polarity), .pixels(pixels));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    // Request holds until pready is seen high; extra edge avoids double drive; the watchdog ends a hung wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [32:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] q;
        apb(1'b1, a, d, q);
        chk(96'(q[32]), 96'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        logic [32:0] q;
        apb(1'b0, a, 32'h0000_0000, q);
        chk(96'(q), 96'(exp));
    endtask : rd

    function automatic logic [7:0] pat(int i);
        return 8'(i * 29 + 7);
    endfunction : pat

    function automatic logic [39:0] rowpat(int r);
        for (int g = 0; g < 5; g++) rowpat[8*g +: 8] = pat(8 * g + r);
    endfunction : rowpat

    // Walks one frame from row 0, checking pixels and polarity; the watchdog ends a stalled scan
    task automatic frame(input logic type_b);
        // Start behind row 7 so row 0 is never taken in the cycle where only the polarity has moved on
        while (!(sel_valid === 1'b1 && sel_row === 3'h7)) begin
            @(posedge pclk);
        end
        for (int r = 0; r < 8; r++) begin
            while (!(sel_valid === 1'b1 && sel_row === 3'(r))) begin
                @(posedge pclk);
            end
            chk(96'(pixels), 96'(rowpat(r)));
            pol[r] = polarity;
            if (r > 0) chk(96'(pol[r] ^ pol[r-1]), 96'(!type_b));
        end
    endtask : frame

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        int n;
        logic hit;
        logic [7:0] r0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 33'h0);
        wr(12'h000, 32'hFFFF_FFFF);
        rd(12'h000, 33'h7);
        rd(12'h008, 33'h1_0000_0000);
        $display("register test done");
        for (int i = 0; i < 40; i++) wr(12'h360 + 12'(4 * i), {24'hFFFF_FF, pat(i)});
        for (int i = 0; i < 40; i++) rd(12'h360 + 12'(4 * i), {25'h0, pat(i)});
        wr(12'h000, 32'h0000_0001);
        frame(1'b0);
        chk(96'({drive_enable, regulator_enable, column_active}), {54'h0, 2'b11, 40'hFF_FFFF_FFFF});
        wr(12'h000, 32'h0000_0005);
        frame(1'b1);
        wr(12'h000, 32'h0000_0007);
        repeat (4) @(posedge pclk);
        n = 0;
        repeat (60) begin
            @(posedge pclk);
            hit = 1'b0;
            for (int r = 0; r < 8; r++) if ((column_drive ^ {40{row_drive[0]}}) === rowpat(r)) hit = 1'b1;
            if ((row_drive !== 8'h00 && row_drive !== 8'hFF) || !hit) n++;
        end
        chk(96'(n), 96'h0);
        wr(12'h000, 32'h0000_0001);
        slow_run <= 1'b0;
        repeat (4) @(posedge pclk);
        r0 = row_drive;
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            if (row_drive !== r0) n++;
        end
        chk(96'(n), 96'h0);
        slow_run <= 1'b1;
        $display("refresh test done");
        wr(12'h000, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk(96'({row_drive, column_drive, column_active, drive_enable}), 96'h0);
        presetn <= 1'b0;
        regulator_option <= 1'b0;
        shared_pad_lcd_select <= 32'h0000_F00F;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 33'h0);
        wr(12'h000, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(96'({regulator_enable, column_active, column_drive & ~column_active}),
            {15'h0, 1'b0, 32'h0000_F00F, 8'hFF, 40'h0});
        $display("strap test done");
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        results();
    end
endmodule : segment_lcd_driver_control_tb
